//--- hw/sar_adc_conversion_readout.sv
`timescale 1ns/1ps
// Behaviour
// - A falling edge on convert_start_n while not busy samples the input and starts a conversion.
// - Busy rises when a conversion starts and falls when it finishes.
// - The host reads the result on the data bus with chip select and read strobe low.
// - In auto sleep the core wakes for a conversion and sleeps again when it ends.
// - The 10-bit variant converts in 12 conversion-clock cycles.
// - The 10-bit variant drives bits 0..9, the 12-bit variant bits 0..11.
// - The result after busy falls belongs to the latest started conversion.
// - Steps advance on the conversion clock, so duration scales with its period.
// - The 12-bit variant converts in 14 conversion-clock cycles.
// - Chip select and read strobe combine through one AND, so they are interchangeable.
// - With both strobes held low the bus stays driven and updates after each conversion.
module sar_adc_conversion_readout #(
   parameter int unsigned WIDTH = sar_adc_pkg::WIDTH_12B,
   parameter int unsigned CONV_DIV = sar_adc_pkg::CONV_CLK_DIV
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic convert_start_n,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic auto_sleep,
   input wire logic [WIDTH-1:0] analog_sample,
   output logic busy,
   output logic asleep,
   output logic [WIDTH-1:0] data_out,
   output logic [WIDTH-1:0] data_oe
);
   localparam int unsigned CONV_CYCLES = (WIDTH == sar_adc_pkg::WIDTH_10B) ?
      sar_adc_pkg::CONV_CYCLES_10B : sar_adc_pkg::CONV_CYCLES_12B;
   localparam int unsigned DW = (CONV_DIV > 1) ? $clog2(CONV_DIV) : 1;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SLEEP,
      ST_CONVERT
   } conv_state_t;

   conv_state_t st_q, st_d;
   logic [4:0] step_q, step_d;
   logic [DW-1:0] div_q, div_d;
   logic conv_tick;
   logic [WIDTH-1:0] sample_q, sample_d;
   logic [WIDTH-1:0] sar_q, sar_d;
   logic [WIDTH-1:0] result_q, result_d;
   logic [WIDTH-1:0] drive_q, drive_d;
   logic conv_s1_q, conv_s2_q, conv_s3_q;
   logic cs_s1_q, cs_s2_q, rd_s1_q, rd_s2_q;
   logic [WIDTH-1:0] ain_s1_q, ain_s2_q;
   logic sleep_s1_q, sleep_s2_q;
   logic start_edge, bus_read, conv_load, conv_step, conv_last;
   logic [WIDTH-1:0] trial_bit;
   logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [WIDTH-1:0] fifo_out_data;

   // State to rest in between conversions
   function automatic conv_state_t rest_state(input logic sleep_en);
      rest_state = sleep_en ? ST_SLEEP : ST_IDLE;
   endfunction

   // One-hot weight of the bit tried at a step, MSB first
   function automatic logic [WIDTH-1:0] trial_weight(input logic [4:0] step);
      trial_weight = '0;
      if (step < 5'(WIDTH)) begin
         trial_weight[WIDTH-1-step] = 1'b1;
      end
   endfunction

   // Keep the trial bit while the trial code does not exceed the held sample
   function automatic logic [WIDTH-1:0] sar_trial(input logic [WIDTH-1:0] sar,
      input logic [WIDTH-1:0] held, input logic [WIDTH-1:0] weight);
      logic [WIDTH-1:0] trial;
      trial = sar | weight;
      sar_trial = (trial <= held) ? trial : sar;
   endfunction

   // Synchronise the pins
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_s1_q <= 1'b1;
         conv_s2_q <= 1'b1;
         conv_s3_q <= 1'b1;
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         rd_s1_q <= 1'b1;
         rd_s2_q <= 1'b1;
         ain_s1_q <= '0;
         ain_s2_q <= '0;
         sleep_s1_q <= 1'b0;
         sleep_s2_q <= 1'b0;
      end else begin
         conv_s1_q <= convert_start_n;
         conv_s2_q <= conv_s1_q;
         conv_s3_q <= conv_s2_q;
         cs_s1_q <= chip_select_n;
         cs_s2_q <= cs_s1_q;
         rd_s1_q <= read_strobe_n;
         rd_s2_q <= rd_s1_q;
         ain_s1_q <= analog_sample;
         ain_s2_q <= ain_s1_q;
         sleep_s1_q <= auto_sleep;
         sleep_s2_q <= sleep_s1_q;
      end
   end

   assign start_edge = conv_s3_q && !conv_s2_q;
   assign bus_read = !(cs_s2_q || rd_s2_q);

   // Conversion clock enable; restarts with each conversion so busy lasts exactly
   // CONV_CYCLES enables whatever the divider phase was
   always_comb begin
      conv_tick = (div_q == DW'(CONV_DIV - 1));
      if (conv_load) begin
         div_d = '0;
      end else if (conv_tick) begin
         div_d = '0;
      end else begin
         div_d = div_q + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_q <= '0;
      end else begin
         div_q <= div_d;
      end
   end

   assign conv_load = start_edge && (st_q != ST_CONVERT);
   assign conv_step = (st_q == ST_CONVERT) && conv_tick && fifo_in_ready;
   assign conv_last = conv_step && (step_q == 5'(CONV_CYCLES - 1));

   // Conversion sequence; start edges during a conversion are ignored
   always_comb begin
      st_d = st_q;
      step_d = step_q;
      case (st_q)
         ST_IDLE: begin
            if (conv_load) begin
               st_d = ST_CONVERT;
               step_d = '0;
            end else begin
               st_d = rest_state(sleep_s2_q);
            end
         end
         ST_SLEEP: begin
            if (conv_load) begin
               st_d = ST_CONVERT;
               step_d = '0;
            end else begin
               st_d = rest_state(sleep_s2_q);
            end
         end
         ST_CONVERT: begin
            if (conv_step) begin
               step_d = step_q + 5'd1;
            end
            if (conv_last) begin
               st_d = rest_state(sleep_s2_q);
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ST_IDLE;
         step_q <= '0;
      end else begin
         st_q <= st_d;
         step_q <= step_d;
      end
   end

   // Sample hold and successive approximation register
   always_comb begin
      sample_d = sample_q;
      sar_d = sar_q;
      result_d = result_q;
      fifo_in_valid = 1'b0;
      trial_bit = trial_weight(step_q);
      if (conv_load) begin
         sample_d = ain_s2_q;
         sar_d = '0;
      end else if (conv_step) begin
         sar_d = sar_trial(sar_q, sample_q, trial_bit);
      end
      if (conv_last) begin
         result_d = sar_q;
         fifo_in_valid = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sample_q <= '0;
         sar_q <= '0;
         result_q <= '0;
      end else begin
         sample_q <= sample_d;
         sar_q <= sar_d;
         result_q <= result_d;
      end
   end

   assign busy = (st_q == ST_CONVERT);
   assign asleep = (st_q == ST_SLEEP);

   result_fifo #(
      .WIDTH(WIDTH),
      .DEPTH(sar_adc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(result_d),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // Keep only the newest result in the bus latch
   assign fifo_out_ready = 1'b1;

   always_comb begin
      drive_d = drive_q;
      if (fifo_out_valid) begin
         drive_d = fifo_out_data;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         drive_q <= '0;
      end else begin
         drive_q <= drive_d;
      end
   end

   assign data_out = drive_q;
   assign data_oe = {WIDTH{bus_read}};
endmodule

//--- pkg/sar_adc_pkg.sv
package sar_adc_pkg;
   // Result widths of the two variants
   localparam int unsigned WIDTH_10B = 10;
   localparam int unsigned WIDTH_12B = 12;
   localparam int unsigned MAX_WIDTH = 12;
   // Conversion length in conversion-clock cycles
   localparam int unsigned CONV_CYCLES_10B = 12;
   localparam int unsigned CONV_CYCLES_12B = 14;
   // Reference figures: time in ns and clock in MHz
   localparam int unsigned CONV_NS_10B = 428;
   localparam int unsigned CLK_MHZ_10B = 28;
   localparam int unsigned CONV_NS_12B = 540;
   localparam int unsigned CLK_MHZ_12B = 26;
   // Host-side acquisition time in ns
   localparam int unsigned ACQ_NS_5V = 130;
   localparam int unsigned ACQ_NS_3V = 140;
   // Ref clock
   localparam int unsigned REF_CLK_MHZ = 50;
   // Default conversion clock divider from ref_clk
   localparam int unsigned CONV_CLK_DIV = 2;
   localparam int unsigned FIFO_DEPTH = 4;
   localparam logic [11:0] RESULT_RESET = 12'h000;

   typedef struct packed {
      logic [MAX_WIDTH-1:0] code;
   } result_t;

   typedef struct packed {
      logic [MAX_WIDTH-1:0] data;
      logic oe;
   } bus_drive_t;
endpackage

//--- hw/result_fifo.sv
`timescale 1ns/1ps
module result_fifo #(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned DEPTH = 4
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic [WIDTH-1:0] dout_q, dout_d;
   logic push, pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rd_q];

   always_comb begin
      wr_d = push ? bump(wr_q) : wr_q;
      rd_d = pop ? bump(rd_q) : rd_q;
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
      dout_d = push ? in_data : dout_q;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         dout_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         dout_q <= dout_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wr_q] <= dout_d;
      end
   end
endmodule

//--- sim/sar_adc_conversion_readout_asserts.sv
`timescale 1ns/1ps
module adc_readout_checker #(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned CONV_DIV = 2
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic convert_start_n,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic auto_sleep,
   input wire logic busy,
   input wire logic asleep,
   input wire logic [WIDTH-1:0] data_out,
   input wire logic [WIDTH-1:0] data_oe
);
   localparam int CONV = (WIDTH == 10 ? 12 : 14) * CONV_DIV;
   logic [7:0] busy_cnt_q, busy_cnt_d;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   always_comb busy_cnt_d = busy ? busy_cnt_q + 8'h01 : 8'h00;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) busy_cnt_q <= 8'h00;
      else busy_cnt_q <= busy_cnt_d;
   end
   busy_length_a: assert property ($fell(busy) |-> busy_cnt_q == CONV)
      else $error("busy length wrong");
   start_busy_a: assert property ($fell(convert_start_n) && !busy |-> ##[3:4] busy)
      else $error("busy did not rise");
   busy_cause_a: assert property ($rose(busy) |-> !$past(convert_start_n, 3))
      else $error("busy rose without start");
   oe_release_a: assert property (chip_select_n || read_strobe_n |-> ##2 data_oe == '0)
      else $error("bus not released");
   oe_drive_a: assert property ((!chip_select_n && !read_strobe_n) [*3] |-> &data_oe)
      else $error("bus not driven");
   oe_whole_a: assert property (data_oe == '0 || &data_oe)
      else $error("partial bus drive");
   result_hold_a: assert property ($changed(data_out) |-> $past(busy, 2) || $past(busy, 3))
      else $error("result changed off conversion end");
   sleep_after_a: assert property (auto_sleep && $fell(busy) |-> ##[0:2] asleep)
      else $error("no sleep after conversion");
   awake_busy_a: assert property (busy |-> !asleep)
      else $error("asleep while busy");
   conv_c: cover property ($fell(busy));
   sleep_c: cover property ($rose(asleep));
   read_c: cover property ($rose(data_oe[0]));
endmodule
bind sar_adc_conversion_readout adc_readout_checker #(.WIDTH(WIDTH), .CONV_DIV(CONV_DIV))
   u_adc_readout_checker (.ref_clk(ref_clk), .rst_b(rst_b), .convert_start_n(convert_start_n),
   .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n), .auto_sleep(auto_sleep),
   .busy(busy), .asleep(asleep), .data_out(data_out), .data_oe(data_oe));

//--- sim/host_model.sv
`timescale 1ns/1ps
module host_model (
   input wire logic ref_clk,
   output logic convert_start_n = 1'b1,
   output logic chip_select_n = 1'b1,
   output logic read_strobe_n = 1'b1
);
   // Start pulse held low six cycles
   task automatic start();
      @(negedge ref_clk) convert_start_n = 1'b0;
      repeat (6) @(negedge ref_clk);
      convert_start_n = 1'b1;
   endtask
   task automatic strobes(input logic cs_n, input logic rd_n);
      @(negedge ref_clk);
      chip_select_n = cs_n;
      read_strobe_n = rd_n;
   endtask
endmodule

//--- sim/sar_adc_conversion_readout_tb.sv
`timescale 1ns/1ps
module sar_adc_conversion_readout_tb;
   localparam int C12 = sar_adc_pkg::CONV_CYCLES_12B * 2;
   localparam int C10 = sar_adc_pkg::CONV_CYCLES_10B * 3;
   logic ref_clk = 1'b0, rst_b = 1'b0, auto_sleep = 1'b0, busy, asleep, busy10, asleep10;
   logic [11:0] sample = 12'h000, data_out, data_oe;
   logic [9:0] data_out10, data_oe10;
   wire cs_n, rd_n, conv_n;
   int n_mismatch = 0, num_checks = 0, len, len10;
   initial forever #10 ref_clk = ~ref_clk;
   host_model u_host_model (.ref_clk(ref_clk), .convert_start_n(conv_n),
      .chip_select_n(cs_n), .read_strobe_n(rd_n));
   sar_adc_conversion_readout #(.WIDTH(12), .CONV_DIV(2)) u_sar_adc_conversion_readout (
      .ref_clk(ref_clk), .rst_b(rst_b), .convert_start_n(conv_n), .chip_select_n(cs_n),
      .read_strobe_n(rd_n), .auto_sleep(auto_sleep), .analog_sample(sample), .busy(busy),
      .asleep(asleep), .data_out(data_out), .data_oe(data_oe));
   sar_adc_conversion_readout #(.WIDTH(10), .CONV_DIV(3)) u_sar_adc_conversion_readout_w10 (
      .ref_clk(ref_clk), .rst_b(rst_b), .convert_start_n(conv_n), .chip_select_n(cs_n),
      .read_strobe_n(rd_n), .auto_sleep(auto_sleep), .analog_sample(sample[9:0]),
      .busy(busy10), .asleep(asleep10), .data_out(data_out10), .data_oe(data_oe10));
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One conversion, optionally a second start during busy; counts busy cycles
   task automatic conv(input logic [11:0] v, input logic again);
      @(negedge ref_clk) sample = v;
      len = 0;
      len10 = 0;
      fork
         begin
            u_host_model.start();
            sample = ~v;
            if (again) u_host_model.start();
         end
      join_none
      repeat (60) @(negedge ref_clk) begin
         len += int'(busy);
         len10 += int'(busy10);
      end
   endtask
   task automatic rd(input logic c, input logic r, input logic [11:0] oe);
      u_host_model.strobes(c, r);
      repeat (4) @(negedge ref_clk);
      check("oe", data_oe, oe);
   endtask
   task automatic t_codes();
      logic [11:0] codes [4] = '{12'h000, 12'hFFF, 12'hA5A, 12'h001};
      check("rst busy", {11'h000, busy}, 12'h000);
      check("rst data", data_out, 12'h000);
      check("rst oe", data_oe, 12'h000);
      foreach (codes[i]) begin
         conv(codes[i], 1'b0);
         check("len", 12'(len), 12'(C12));
         check("len10", 12'(len10), 12'(C10));
         check("data", data_out, codes[i]);
         check("data10", 12'(data_out10), {2'b00, codes[i][9:0]});
         check("oe", data_oe, 12'h000);
      end
      $display("end codes");
   endtask
   task automatic t_retrig();
      conv(12'h3C7, 1'b1);
      check("len", 12'(len), 12'(C12));
      check("data", data_out, 12'h3C7);
      $display("end retrigger");
   endtask
   task automatic t_read();
      rd(1'b0, 1'b1, 12'h000);
      rd(1'b0, 1'b0, 12'hFFF);
      check("rdata", data_out, 12'h3C7);
      check("rdata10", 12'(data_out10), 12'h3C7);
      rd(1'b1, 1'b0, 12'h000);
      check("oe10", 12'(data_oe10), 12'h000);
      rd(1'b0, 1'b0, 12'hFFF);
      check("oe10", 12'(data_oe10), 12'h3FF);
      $display("end read");
   endtask
   task automatic t_hold();
      conv(12'h5A5, 1'b0);
      check("data", data_out, 12'h5A5);
      check("oe", data_oe, 12'hFFF);
      rd(1'b1, 1'b1, 12'h000);
      $display("end hold");
   endtask
   task automatic t_sleep();
      @(negedge ref_clk) auto_sleep = 1'b1;
      conv(12'h777, 1'b0);
      check("asleep", {11'h000, asleep}, 12'h001);
      check("asleep10", {11'h000, asleep10}, 12'h001);
      check("len10", 12'(len10), 12'(C10));
      check("len", 12'(len), 12'(C12));
      $display("end sleep");
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge ref_clk);
      rst_b = 1'b1;
      t_codes();
      t_retrig();
      t_read();
      t_hold();
      t_sleep();
      finish_test();
   end
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_mismatch++;
      finish_test();
   end
endmodule
